/* File: psv_consts.svh */
// Constants for the process load and stall supervisor.
`ifndef PSV_CONSTS_SVH
`define PSV_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
// Clock period in ns (25 MHz).
`define PSV_CLK_NS 40
// Supervision time tick in ms; all delays count in these ticks.
`define PSV_TICK_MS 100
// Nanoseconds in one millisecond.
`define PSV_NS_PER_MS 1000000
// Ticks in one minute.
`define PSV_TICKS_PER_MIN 13'h0258
// Lockout margin the fault reset time must exceed, in minutes.
`define PSV_RESET_MARGIN_MIN 4'h1

// ****************************************************************
// Setting limits (times 0.1 s, frequencies 0.1 Hz, percent as noted)
// ****************************************************************
// Longest underload or overload delay, 100 s.
`define PSV_DELAY_MAX 12'h3e8
// Longest stall time, 200 s.
`define PSV_STALL_TIME_MAX 12'h7d0
// Smallest steady state hysteresis, 0.3 Hz.
`define PSV_HYST_MIN 16'h0003
// Largest hysteresis and minimum underload frequency, 599.0 Hz.
`define PSV_FREQ_MAX 16'h1766
// Nominal speed underload threshold range, whole percent.
`define PSV_UL_NOM_MIN 8'h14
`define PSV_UL_NOM_MAX 8'h64
// Overload current threshold range, whole percent.
`define PSV_OL_THR_MIN 8'h46
`define PSV_OL_THR_MAX 8'h96
// Longest restart lockout, minutes.
`define PSV_LOCKOUT_MAX 4'h6
// Tenths of a percent in one percent.
`define PSV_PCT_SCALE 16'h000a

// ****************************************************************
// Factory values
// ****************************************************************
`define PSV_DEF_HYST 16'h0003
`define PSV_DEF_UL_NOM 8'h3c
`define PSV_DEF_UL_ZERO 8'h00
`define PSV_DEF_OL_THR 8'h6e
`define PSV_DEF_STALL_TIME 12'h258
`define PSV_DEF_STALL_CUR 16'h05dc
`define PSV_DEF_STALL_FREQ 16'h0014

`endif

/* File: psv_pkg.sv */
// Types shared by the process load and stall supervisor.
package psv_pkg;

    // Stop reaction selected for a detected error.
    typedef enum logic [1:0] {
        PSV_REACT_IGNORE = 2'b00,
        PSV_REACT_FREEWHEEL = 2'b01,
        PSV_REACT_RAMP = 2'b10,
        PSV_REACT_FAST = 2'b11
    } psv_react_t;

    // Measurements from the drive control loop.
    typedef struct packed {
        logic [15:0] freq_ref;
        logic [15:0] motor_freq;
        logic [15:0] torque;
        logic [15:0] current;
        logic current_limit_state;
    } psv_meas_t;

    // Supervision settings.
    typedef struct packed {
        logic [15:0] rated_freq;
        logic [11:0] underload_delay;
        logic [7:0] underload_thr_nominal;
        logic [7:0] underload_thr_zero_speed;
        logic [15:0] underload_min_freq;
        logic [15:0] steady_state_hysteresis;
        psv_react_t underload_reaction;
        logic [3:0] underload_restart_lockout;
        logic [11:0] overload_delay;
        logic [7:0] overload_current_thr;
        psv_react_t overload_reaction;
        logic [3:0] overload_restart_lockout;
        logic stall_enable;
        logic [11:0] stall_time;
        logic [15:0] stall_current_thr;
        logic [15:0] stall_freq_thr;
        logic [3:0] fault_reset_time;
    } psv_cfg_t;

    // Stop commands to the drive sequencer.
    typedef struct packed {
        logic freewheel;
        logic ramp;
        logic fast;
    } psv_stop_t;

endpackage

/* File: psv_persist.sv */
// Persistence timer: fires once a condition has held for a set time.
`timescale 1ns/1ns
module psv_persist #(
    parameter int WIDTH = 12
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Time base and condition.
    input wire logic tick,
    input wire logic cond,
    input wire logic [WIDTH-1:0] limit,
    // Condition has persisted for the whole limit.
    output logic fire
);

    // Ticks counted while the condition holds.
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    // Counts ticks while the condition holds and stops at the limit.
    always_comb
    begin
        cnt_d = cnt_q;
        if (!cond)
        begin
            cnt_d = '0;
        end
        else if (tick && cnt_q < limit)
        begin
            cnt_d = cnt_q + WIDTH'(1);
        end
    end

    // Registers the count.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // Only an uninterrupted interval reaching the limit fires.
    assign fire = cond && (cnt_q >= limit);

endmodule

/* File: psv_supervisor.sv */
// Process underload, overload and stall supervision for a motor drive.
// ****************************************************************
// ****************************************************************
`include "psv_consts.svh"
`timescale 1ns/1ns
module psv_supervisor #(
    parameter int TICK_CYCLES = (`PSV_TICK_MS * `PSV_NS_PER_MS) / `PSV_CLK_NS
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Drive measurements and settings.
    input wire psv_pkg::psv_meas_t meas,
    input wire psv_pkg::psv_cfg_t cfg,
    // Fault acknowledge pulse from the drive sequencer.
    input wire logic fault_clear,
    // Error flags, usable on relays or digital outputs.
    output logic underload_error,
    output logic overload_error,
    output logic stall_error,
    // Stop command and restart permission.
    output psv_pkg::psv_stop_t stop,
    output logic restart_ok
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Absolute difference of two unsigned values.
    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        abs_diff = (a > b) ? (a - b) : (b - a);
    endfunction

    // Clamps a value into a range.
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
        if (v < lo)
        begin
            clamp = lo;
        end
        else if (v > hi)
        begin
            clamp = hi;
        end
        else
        begin
            clamp = v;
        end
    endfunction

    // Converts whole percent to tenths of a percent.
    function automatic logic [15:0] pct_tenths(input logic [7:0] p);
        pct_tenths = 16'({8'h00, p} * `PSV_PCT_SCALE);
    endfunction

    // Converts minutes to supervision ticks.
    function automatic logic [12:0] min_ticks(input logic [3:0] m);
        min_ticks = 13'({9'h000, m} * `PSV_TICKS_PER_MIN);
    endfunction

    // Restart permission: lockout elapsed and reset time beyond it.
    function automatic logic permit(input logic [12:0] left, input logic [3:0] lock,
                                    input logic [3:0] reset_time);
        permit = (left == 13'h0000) &&
                 ({1'b0, reset_time} >= ({1'b0, lock} + {1'b0, `PSV_RESET_MARGIN_MIN}));
    endfunction

    // ****************************************************************
    // Time tick
    // ****************************************************************

    // Prescaler counting clock cycles per supervision tick.
    logic [31:0] pre_q;
    logic [31:0] pre_d;
    // One cycle pulse every tick period.
    logic tick;

    // Wraps the prescaler once per tick period.
    always_comb
    begin
        if (pre_q >= 32'(TICK_CYCLES - 1))
        begin
            pre_d = 32'h00000000;
        end
        else
        begin
            pre_d = pre_q + 32'h00000001;
        end
    end

    // Registers the prescaler.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pre_q <= 32'h00000000;
        end
        else
        begin
            pre_q <= pre_d;
        end
    end

    assign tick = (pre_q >= 32'(TICK_CYCLES - 1));

    // ****************************************************************
    // Setting limits and enables
    // ****************************************************************

    // Delays held inside their ranges.
    logic [11:0] ul_delay;
    logic [11:0] ol_delay;
    logic [11:0] st_time;
    // Thresholds in tenths of a percent and frequencies in 0.1 Hz.
    logic [15:0] ul_nom;
    logic [15:0] ul_zero;
    logic [15:0] ol_thr;
    logic [15:0] hyst;
    logic [15:0] ul_fmin;
    // Lockouts in minutes.
    logic [3:0] ul_lock;
    logic [3:0] ol_lock;
    // Supervision enables.
    logic ul_en;
    logic ol_en;
    logic st_en;

    // Limits the delays, underload and overload thresholds, hysteresis, minimum frequency and lockouts to their ranges.
    always_comb
    begin
        ul_delay = 12'(clamp({4'h0, cfg.underload_delay}, 16'h0000,
                             {4'h0, `PSV_DELAY_MAX}));
        ol_delay = 12'(clamp({4'h0, cfg.overload_delay}, 16'h0000,
                             {4'h0, `PSV_DELAY_MAX}));
        st_time = 12'(clamp({4'h0, cfg.stall_time}, 16'h0000,
                            {4'h0, `PSV_STALL_TIME_MAX}));
        ul_nom = clamp(pct_tenths(cfg.underload_thr_nominal), pct_tenths(`PSV_UL_NOM_MIN),
                       pct_tenths(`PSV_UL_NOM_MAX));
        ul_zero = clamp(pct_tenths(cfg.underload_thr_zero_speed), 16'h0000, ul_nom);
        ol_thr = clamp(pct_tenths(cfg.overload_current_thr), pct_tenths(`PSV_OL_THR_MIN),
                       pct_tenths(`PSV_OL_THR_MAX));
        hyst = clamp(cfg.steady_state_hysteresis, `PSV_HYST_MIN, `PSV_FREQ_MAX);
        ul_fmin = clamp(cfg.underload_min_freq, 16'h0000, `PSV_FREQ_MAX);
        ul_lock = 4'(clamp({12'h000, cfg.underload_restart_lockout}, 16'h0000,
                           {12'h000, `PSV_LOCKOUT_MAX}));
        ol_lock = 4'(clamp({12'h000, cfg.overload_restart_lockout}, 16'h0000,
                           {12'h000, `PSV_LOCKOUT_MAX}));
        ul_en = (ul_delay != 12'h000);
        ol_en = (ol_delay != 12'h000);
        st_en = cfg.stall_enable;
    end

    // ****************************************************************
    // Detection conditions
    // ****************************************************************

    // Motor is in steady state.
    logic steady;
    // Frequency squared and rated frequency squared.
    logic [31:0] f_sq;
    logic [31:0] fr_sq;
    // Underload torque threshold at the present frequency.
    logic [15:0] ul_thr;
    // Raw conditions for each supervision.
    logic ul_cond;
    logic ol_cond;
    logic st_cond;

    // Evaluates the three supervision conditions.
    always_comb
    begin
        steady = abs_diff(meas.freq_ref, meas.motor_freq) < hyst;
        f_sq = {16'h0000, meas.motor_freq} * {16'h0000, meas.motor_freq};
        fr_sq = {16'h0000, cfg.rated_freq} * {16'h0000, cfg.rated_freq};
        if (meas.motor_freq >= cfg.rated_freq || fr_sq == 32'h00000000)
        begin
            ul_thr = ul_nom;
        end
        else
        begin
            ul_thr = ul_zero + 16'((48'({16'h0000, ul_nom - ul_zero}) * 48'(f_sq))
                                   / 48'(fr_sq));
        end
        ul_cond = ul_en && steady && (meas.motor_freq >= ul_fmin) &&
                  (meas.torque < ul_thr);
        ol_cond = ol_en && (meas.current_limit_state ||
                  (steady && meas.current > ol_thr));
        st_cond = st_en && (meas.motor_freq < cfg.stall_freq_thr) &&
                  (meas.current > cfg.stall_current_thr);
    end

    // ****************************************************************
    // Persistence timers
    // ****************************************************************

    // Conditions that have persisted for their set time.
    logic ul_fire;
    logic ol_fire;
    logic st_fire;

    psv_persist #(.WIDTH(12)) u_ul_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .cond(ul_cond),
        .limit(ul_delay),
        .fire(ul_fire)
    );

    psv_persist #(.WIDTH(12)) u_ol_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .cond(ol_cond),
        .limit(ol_delay),
        .fire(ol_fire)
    );

    psv_persist #(.WIDTH(12)) u_st_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick),
        .cond(st_cond),
        .limit(st_time),
        .fire(st_fire)
    );

    // ****************************************************************
    // Error flags, lockouts and reactions
    // ****************************************************************

    // Latched errors.
    logic ul_err_q;
    logic ul_err_d;
    logic ol_err_q;
    logic ol_err_d;
    logic st_err_q;
    logic st_err_d;
    // Lockout ticks still to run.
    logic [12:0] ul_left_q;
    logic [12:0] ul_left_d;
    logic [12:0] ol_left_q;
    logic [12:0] ol_left_d;
    // Registered stop command and restart permission.
    psv_pkg::psv_stop_t stop_q;
    psv_pkg::psv_stop_t stop_d;
    logic restart_q;
    logic restart_d;
    // Reactions in force for the errors now latched.
    psv_pkg::psv_react_t ul_react;
    psv_pkg::psv_react_t ol_react;
    // An ignored error neither latches nor starts a lockout.
    logic ul_act;
    logic ol_act;

    // Computes error latches, lockouts, stop command and permission.
    always_comb
    begin
        ul_react = cfg.underload_reaction;
        ol_react = cfg.overload_reaction;
        ul_act = ul_en && ul_react != psv_pkg::PSV_REACT_IGNORE;
        ol_act = ol_en && ol_react != psv_pkg::PSV_REACT_IGNORE;
        // A new detection wins over an acknowledge in the same cycle.
        ul_err_d = ul_act && ((ul_fire) || (ul_err_q && !fault_clear));
        ol_err_d = ol_act && ((ol_fire) || (ol_err_q && !fault_clear));
        st_err_d = st_en && ((st_fire) || (st_err_q && !fault_clear));
        ul_left_d = ul_left_q;
        if (!ul_act)
        begin
            ul_left_d = 13'h0000;
        end
        else if (ul_fire && !ul_err_q)
        begin
            ul_left_d = min_ticks(ul_lock);
        end
        else if (tick && ul_left_q != 13'h0000)
        begin
            ul_left_d = ul_left_q - 13'h0001;
        end
        ol_left_d = ol_left_q;
        if (!ol_act)
        begin
            ol_left_d = 13'h0000;
        end
        else if (ol_fire && !ol_err_q)
        begin
            ol_left_d = min_ticks(ol_lock);
        end
        else if (tick && ol_left_q != 13'h0000)
        begin
            ol_left_d = ol_left_q - 13'h0001;
        end
        stop_d.freewheel = st_err_d ||
                           (ul_err_d && ul_react == psv_pkg::PSV_REACT_FREEWHEEL) ||
                           (ol_err_d && ol_react == psv_pkg::PSV_REACT_FREEWHEEL);
        stop_d.fast = !stop_d.freewheel &&
                      ((ul_err_d && ul_react == psv_pkg::PSV_REACT_FAST) ||
                       (ol_err_d && ol_react == psv_pkg::PSV_REACT_FAST));
        stop_d.ramp = !stop_d.freewheel && !stop_d.fast &&
                      ((ul_err_d && ul_react == psv_pkg::PSV_REACT_RAMP) ||
                       (ol_err_d && ol_react == psv_pkg::PSV_REACT_RAMP));
        restart_d = !ul_err_d && !ol_err_d && !st_err_d &&
                    (!ul_act || permit(ul_left_d, ul_lock, cfg.fault_reset_time)) &&
                    (!ol_act || permit(ol_left_d, ol_lock, cfg.fault_reset_time));
    end

    // Registers error latches, lockouts and outputs.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ul_err_q <= 1'b0;
            ol_err_q <= 1'b0;
            st_err_q <= 1'b0;
            ul_left_q <= 13'h0000;
            ol_left_q <= 13'h0000;
            stop_q <= '0;
            restart_q <= 1'b0;
        end
        else
        begin
            ul_err_q <= ul_err_d;
            ol_err_q <= ol_err_d;
            st_err_q <= st_err_d;
            ul_left_q <= ul_left_d;
            ol_left_q <= ol_left_d;
            stop_q <= stop_d;
            restart_q <= restart_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign underload_error = ul_err_q;
    assign overload_error = ol_err_q;
    assign stall_error = st_err_q;
    assign stop = stop_q;
    assign restart_ok = restart_q;

endmodule

/* File: psv_chk_sva.sv */
// Port checker for the process load and stall supervisor.
`timescale 1ns/1ns
module psv_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Supervisor inputs.
    input wire psv_pkg::psv_meas_t meas,
    input wire psv_pkg::psv_cfg_t cfg,
    // Supervisor outputs.
    input wire logic underload_error,
    input wire logic overload_error,
    input wire logic stall_error,
    input wire psv_pkg::psv_stop_t stop,
    input wire logic restart_ok
);
    // ****************
    // Helpers
    // ****************
    // Frequency error, steady state flag and any latched error.
    logic [15:0] fdiff;
    logic steady;
    logic any_err;
    assign fdiff = (meas.freq_ref > meas.motor_freq) ? meas.freq_ref - meas.motor_freq
        : meas.motor_freq - meas.freq_ref;
    assign steady = (fdiff < 16'h0003) || (fdiff < cfg.steady_state_hysteresis);
    assign any_err = underload_error | overload_error | stall_error;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ****************
    // Properties
    // ****************
    property p_ul_off;
        $rose(underload_error) |-> $past(cfg.underload_delay != 12'h000
            && cfg.underload_reaction != psv_pkg::PSV_REACT_IGNORE);
    endproperty
    property p_ol_off;
        $rose(overload_error) |-> $past(cfg.overload_delay) != 12'h000;
    endproperty
    property p_ul_cause;
        $rose(underload_error) |-> $past(steady && meas.motor_freq >= cfg.underload_min_freq);
    endproperty
    property p_ol_cause;
        $rose(overload_error) |-> $past(meas.current_limit_state || (steady
            && meas.current > {8'h00, cfg.overload_current_thr} * 16'h000a));
    endproperty
    property p_st_cause;
        $rose(stall_error) |-> $past(cfg.stall_enable && meas.motor_freq < cfg.stall_freq_thr
            && meas.current > cfg.stall_current_thr);
    endproperty
    property p_stop_one;
        $onehot0({stop.freewheel, stop.ramp, stop.fast});
    endproperty
    property p_no_restart;
        $past(any_err) && any_err |-> !restart_ok;
    endproperty
    property p_st_stop;
        stall_error ##1 stall_error |-> stop.freewheel;
    endproperty
    a_ul_off: assert property (p_ul_off) else $error("underload raised while off");
    a_ol_off: assert property (p_ol_off) else $error("overload raised while off");
    a_ul_cause: assert property (p_ul_cause) else $error("underload without cause");
    a_ol_cause: assert property (p_ol_cause) else $error("overload without cause");
    a_st_cause: assert property (p_st_cause) else $error("stall without cause");
    a_stop_one: assert property (p_stop_one) else $error("two stop commands");
    a_no_restart: assert property (p_no_restart) else $error("restart with error");
    a_st_stop: assert property (p_st_stop) else $error("stall without stop");
    c_ul: cover property ($rose(underload_error));
    c_ol: cover property ($rose(overload_error));
    c_st: cover property ($rose(stall_error));
endmodule

/* File: psv_drive_model.sv */
// Behavioural drive control loop feeding the supervisor.
`timescale 1ns/1ns
module psv_drive_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Operating point set by the bench.
    input wire logic [15:0] ref_cmd,
    input wire logic [15:0] slew,
    input wire logic [15:0] torque_cmd,
    input wire logic [15:0] current_cmd,
    input wire logic limit_cmd,
    // Measurements towards the supervisor.
    output psv_pkg::psv_meas_t meas
);
    // Motor frequency follows the reference by slew per cycle; zero jumps at once.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            meas <= '0;
        else
        begin
            meas.freq_ref <= ref_cmd;
            meas.torque <= torque_cmd;
            meas.current <= current_cmd;
            meas.current_limit_state <= limit_cmd;
            if (slew != 16'h0000 && meas.motor_freq + slew < ref_cmd)
                meas.motor_freq <= meas.motor_freq + slew;
            else if (slew != 16'h0000 && meas.motor_freq > ref_cmd + slew)
                meas.motor_freq <= meas.motor_freq - slew;
            else
                meas.motor_freq <= ref_cmd;
        end
    end
endmodule

/* File: test_psv_supervisor.sv */
// Self-checking bench of the process load and stall supervisor.
`timescale 1ns/1ns
bind psv_supervisor psv_chk u_chk (.clk(clk), .rst_n(rst_n), .meas(meas), .cfg(cfg),
    .underload_error(underload_error), .overload_error(overload_error),
    .stall_error(stall_error), .stop(stop), .restart_ok(restart_ok));
module test_psv_supervisor;
    localparam int TC = 4; // Clocks in one supervision tick.
    logic clk, rst_n, fault_clear, limit_cmd, ul_e, ol_e, st_e, restart_ok;
    logic [15:0] ref_cmd, slew, torque_cmd, current_cmd;
    psv_pkg::psv_meas_t meas;
    psv_pkg::psv_cfg_t cfg;
    psv_pkg::psv_stop_t stop;
    int fail_count, num_checks, f, thr;
    psv_drive_model u_drv (.clk(clk), .rst_n(rst_n), .ref_cmd(ref_cmd), .slew(slew),
        .torque_cmd(torque_cmd), .current_cmd(current_cmd), .limit_cmd(limit_cmd), .meas(meas));
    psv_supervisor #(.TICK_CYCLES(TC)) uut (.clk(clk), .rst_n(rst_n), .meas(meas), .cfg(cfg),
        .fault_clear(fault_clear), .underload_error(ul_e), .overload_error(ol_e),
        .stall_error(st_e), .stop(stop), .restart_ok(restart_ok));
    // Free running clock.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Counts a compare and reports a mismatch.
    task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Waits n cycles, landing between edges where outputs are settled.
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    // Sets the operating point of the drive model at a rising edge.
    task automatic drive(int r, int s, int t, int c, logic l);
        @(posedge clk);
        ref_cmd <= 16'(r);
        slew <= 16'(s);
        torque_cmd <= 16'(t);
        current_cmd <= 16'(c);
        limit_cmd <= l;
    endtask
    // Stop pattern expected for a reaction.
    function automatic logic [3:0] stop_of(psv_pkg::psv_react_t r);
        return {1'b0, r == psv_pkg::PSV_REACT_FREEWHEEL, r == psv_pkg::PSV_REACT_RAMP,
            r == psv_pkg::PSV_REACT_FAST};
    endfunction
    // Underload torque limit in 0.1 percent at frequency fr.
    function automatic int ul_thr(int fr);
        int z = 10 * cfg.underload_thr_zero_speed;
        int n = 10 * cfg.underload_thr_nominal;
        return z + (n - z) * fr * fr / (cfg.rated_freq * cfg.rated_freq);
    endfunction
    // Checks the flags just before and after a persistence of ln ticks.
    task automatic persist(int ln, logic [3:0] exp, logic [3:0] stp);
        cyc((ln - 1) * TC - 1);
        check("flags early", {1'b0, ul_e, ol_e, st_e}, 4'h0);
        cyc(TC + 6);
        check("flags", {1'b0, ul_e, ol_e, st_e}, exp);
        check("stop", {1'b0, stop}, stp);
    endtask
    // Returns to a quiet point and acknowledges the errors.
    task automatic quiet();
        drive(300, 0, 1000, 500, 1'b0);
        @(posedge clk);
        fault_clear <= 1'b1;
        @(posedge clk);
        fault_clear <= 1'b0;
        cyc(2);
        check("flags cleared", {1'b0, ul_e, ol_e, st_e}, 4'h0);
    endtask
    // Ends the run with the counts and the verdict.
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Cuts a hang short.
    initial
    begin
        #(40 * 40000);
        fail_count++;
        give_verdict();
    end
    // Main sequence.
    initial
    begin
        fail_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        fault_clear = 1'b0;
        {ref_cmd, slew, torque_cmd, current_cmd, limit_cmd} = {16'h012c, 16'h0000, 16'h03e8,
            16'h01f4, 1'b0};
        cfg = '{16'h01f4, 12'h000, 8'h3c, 8'h14, 16'h0000, 16'h0003, psv_pkg::PSV_REACT_FREEWHEEL,
            4'h0, 12'h000, 8'h6e, psv_pkg::PSV_REACT_FREEWHEEL, 4'h0, 1'b0, 12'h000, 16'h05dc,
            16'h0014, 4'h1};
        void'($urandom(32'h2724c3b2));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cyc(3);
        check("restart after reset", {3'b000, restart_ok}, 4'h1);
        for (int r = 0; r < 4; r++)
        begin
            f = 100 + $urandom_range(400);
            thr = ul_thr(f);
            drive(f, 0, thr + 10, 500, 1'b0);
            cfg.underload_delay <= 12'(2 + r);
            cfg.underload_reaction <= psv_pkg::psv_react_t'(2'(r));
            persist(2 + r, 4'h0, 4'h0);
            drive(f, 0, thr - 10, 500, 1'b0);
            persist(2 + r, (r == 0) ? 4'h0 : 4'h4, stop_of(psv_pkg::psv_react_t'(2'(r))));
            quiet();
        end
        drive(f, 0, 0, 500, 1'b0);
        cfg.underload_min_freq <= 16'(f + 1);
        persist(5, 4'h0, 4'h0);
        drive(2000, 1, 0, 500, 1'b0);
        cfg.underload_min_freq <= 16'h0000;
        persist(5, 4'h0, 4'h0);
        drive(300, 0, 0, 500, 1'b0);
        cfg.underload_delay <= 12'h000;
        persist(2, 4'h0, 4'h0);
        drive(300, 0, 1000, 1100, 1'b0);
        cfg.overload_delay <= 12'h002;
        persist(2, 4'h0, 4'h0);
        for (int r = 0; r < 4; r++)
        begin
            if (r % 2 == 0)
                drive(300, 0, 1000, 1105, 1'b0);
            else
                drive(2000, 1, 1000, 500, 1'b1);
            cfg.overload_delay <= 12'(2 + r);
            cfg.overload_reaction <= psv_pkg::psv_react_t'(2'(r));
            persist(2 + r, (r == 0) ? 4'h0 : 4'h2, stop_of(psv_pkg::psv_react_t'(2'(r))));
            quiet();
        end
        @(posedge clk);
        cfg.overload_reaction <= psv_pkg::PSV_REACT_FREEWHEEL;
        repeat (4)
        begin
            drive(300, 0, 1000, 1105, 1'b0);
            cyc(7);
            drive(300, 0, 1000, 500, 1'b0);
        end
        cyc(2);
        check("broken overload", {1'b0, ul_e, ol_e, st_e}, 4'h0);
        drive(10, 0, 1000, 1600, 1'b0);
        cfg.overload_delay <= 12'h000;
        cfg.stall_time <= 12'(2 + $urandom_range(2));
        persist(4, 4'h0, 4'h0);
        drive(10, 0, 1000, 1600, 1'b0);
        cfg.stall_enable <= 1'b1;
        persist(int'(cfg.stall_time), 4'h1, stop_of(psv_pkg::PSV_REACT_FREEWHEEL));
        quiet();
        drive(300, 0, 0, 500, 1'b0);
        cfg.stall_enable <= 1'b0;
        cfg.underload_delay <= 12'h002;
        cfg.underload_restart_lockout <= 4'h1;
        cfg.fault_reset_time <= 4'h2;
        persist(2, 4'h4, stop_of(psv_pkg::PSV_REACT_FAST));
        quiet();
        check("restart in lockout", {3'b000, restart_ok}, 4'h0);
        cyc(2000);
        check("restart in lockout", {3'b000, restart_ok}, 4'h0);
        cyc(500);
        check("restart after lockout", {3'b000, restart_ok}, 4'h1);
        @(posedge clk);
        cfg.fault_reset_time <= 4'h1;
        cyc(3);
        check("restart margin", {3'b000, restart_ok}, 4'h0);
        give_verdict();
    end
endmodule
